/* File: core/dsw_frontend.v */
// serial write front end: 24-bit frame shift, execute or abort
// Behaviour
// - 24-bit shift register samples data on falling serial clock edges.
// - low frame select enables shifting on the following falling edges.
// - on the 24th falling edge the frame executes and updates data.
// - select rising before the 24th edge aborts; partial frame dropped.
// - two power mode bits select normal or one of three power-down modes.
// - sixteen data bits load the converter register on a valid frame.
// - on abort, shift register cleared; data and mode unchanged.
// - new frame starts only on falling frame select; may stay low after.
`default_nettype none
`include "dsw_map.vh"
module dsw_frontend
(
  input  wire        sys_clk_i,
  input  wire        reset_n_i,
  input  wire        frame_sel_n_i,
  input  wire        ser_clk_i,
  input  wire        ser_data_i,
  output reg  [15:0] dac_data_o,
  output reg  [1:0]  power_mode_o,
  output wire        power_mode_bit_high_o,
  output wire        power_mode_bit_low_o,
  output reg         update_o,
  output reg         abort_o,
  output wire        busy_o
);
  localparam ST_IDLE = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_DONE = 2'h2;
  // idle waits for select to fall; shift collects bits and aborts when
  // select rises; done has executed and ignores further clock edges
  // until select goes high again

  wire                   fs_n_s;
  wire                   sclk_s;
  wire                   sdat_s;
  reg                    fs_n_d_r;
  reg                    sclk_d_r;
  reg  [1:0]             state_r;
  reg  [1:0]             state_nxt;
  reg  [`DSW_CNT_W-1:0]  cnt_r;
  reg  [`DSW_CNT_W-1:0]  cnt_nxt;
  reg  [23:0]            shift_r;
  reg  [23:0]            shift_nxt;
  reg  [15:0]            data_nxt;
  reg  [1:0]             mode_nxt;
  reg                    upd_nxt;
  reg                    abt_nxt;
  wire                   fs_fall;
  wire                   fs_rise;
  wire                   sclk_fall;
  wire [23:0]            shifted;

  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  // clock and data pass through equal depths, so the data level seen with
  // a detected clock fall is the level that stood at the pin edge
  // select pulses or clock phases shorter than one system clock can be
  // lost: the serial clock must run far below the system clock
  dsw_sync2 u_sync_fs
  (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (frame_sel_n_i),
    .rst_val_i (1'b1),
    .sync_o    (fs_n_s)
  );
  // serial clock idles high, so it resets high and no edge follows reset
  dsw_sync2 u_sync_sclk
  (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (ser_clk_i),
    .rst_val_i (1'b1),
    .sync_o    (sclk_s)
  );
  dsw_sync2 u_sync_sdat
  (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (ser_data_i),
    .rst_val_i (1'b0),
    .sync_o    (sdat_s)
  );

  ////////////////////////////////////////////////////////////////////////
  // edge detection on synchronised levels
  // delayed copies reset to the idle levels of their pins
  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      fs_n_d_r <= 1'b1;
      sclk_d_r <= 1'b1;
    end
    else
    begin
      fs_n_d_r <= fs_n_s;
      sclk_d_r <= sclk_s;
    end
  end

  // edge decode shared by the select and clock detectors
  function edge_seen;
    input prev_lvl;
    input now_lvl;
    input want_rise;
    begin
      if (want_rise)
        edge_seen = ~prev_lvl & now_lvl;
      else
        edge_seen = prev_lvl & ~now_lvl;
    end
  endfunction

  // one-cycle strobes from the synchronised levels
  assign fs_fall   = edge_seen(fs_n_d_r, fs_n_s, 1'b0);
  assign fs_rise   = edge_seen(fs_n_d_r, fs_n_s, 1'b1);
  assign sclk_fall = edge_seen(sclk_d_r, sclk_s, 1'b0);
  assign shifted   = {shift_r[22:0], sdat_s};

  ////////////////////////////////////////////////////////////////////////
  // frame state machine
  // one frame at a time; the counter holds the bits taken so far
  always @*
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    data_nxt  = dac_data_o;
    mode_nxt  = power_mode_o;
    upd_nxt   = 1'b0;
    abt_nxt   = 1'b0;
    case (state_r)
      ST_IDLE:
      begin
        // clock edges here belong to no frame and are dropped
        // start on falling select
        if (fs_fall)
        begin
          state_nxt = ST_SHIFT;
          cnt_nxt   = `DSW_CNT_RST;
          shift_nxt = `DSW_SHIFT_RST;
        end
      end
      ST_SHIFT:
      begin
        // select is looked at before the clock, so a rise seen in the
        // same cycle as the last fall still counts as an abort
        // early rise aborts
        if (fs_n_s)
        begin
          state_nxt = ST_IDLE;
          // outputs hold; only the pulse reports the abort
          // clear, keep outputs
          shift_nxt = `DSW_SHIFT_RST;
          cnt_nxt   = `DSW_CNT_RST;
          abt_nxt   = 1'b1;
        end
        else if (sclk_fall)
        begin
          shift_nxt = shifted;
          cnt_nxt   = cnt_r + 5'h01;
          if (cnt_r == `DSW_CNT_LAST)
          begin
            state_nxt = ST_DONE;
            // six leading bits shift through and are never read
            // load data bits
            data_nxt  = shifted[`DSW_DATA_LSB +: `DSW_DATA_W];
            mode_nxt  = shifted[`DSW_MODE_LSB +: `DSW_MODE_W];
            upd_nxt   = 1'b1;
            cnt_nxt   = `DSW_CNT_RST;
          end
        end
      end
      ST_DONE:
      begin
        // a new frame needs select to rise and fall again
        // wait for select high
        if (fs_rise)
          state_nxt = ST_IDLE;
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // state and output registers
  // data and mode outputs only move with an executed frame
  // reset gives zero data and normal mode
  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      state_r      <= ST_IDLE;
      cnt_r        <= `DSW_CNT_RST;
      shift_r      <= `DSW_SHIFT_RST;
      dac_data_o   <= `DSW_DATA_RST;
      power_mode_o <= `DSW_MODE_RST;
      update_o     <= 1'b0;
      abort_o      <= 1'b0;
    end
    else
    begin
      state_r      <= state_nxt;
      cnt_r        <= cnt_nxt;
      shift_r      <= shift_nxt;
      dac_data_o   <= data_nxt;
      power_mode_o <= mode_nxt;
      update_o     <= upd_nxt;
      abort_o      <= abt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode bit pins and activity flag
  // busy covers only the collecting phase, not a held-low done state
  assign power_mode_bit_high_o = power_mode_o[1];
  assign power_mode_bit_low_o  = power_mode_o[0];
  assign busy_o                = (state_r == ST_SHIFT);
endmodule
`default_nettype wire

/* File: core/dsw_map.vh */
// constants for the serial write front end
`ifndef DSW_MAP_VH
`define DSW_MAP_VH
`define DSW_FRAME_BITS      24
`define DSW_CNT_W           5
`define DSW_DATA_W          16
`define DSW_DATA_LSB        0
`define DSW_MODE_LSB        16
`define DSW_MODE_W          2
`define DSW_CNT_RST         5'h00
`define DSW_CNT_LAST        5'h17
`define DSW_DATA_RST        16'h0000
`define DSW_MODE_RST        2'h0
`define DSW_SHIFT_RST       24'h000000
`endif

/* File: core/dsw_sync2.v */
// two flip-flop synchroniser for one asynchronous input
`default_nettype none
module dsw_sync2
(
  input  wire sys_clk_i,
  input  wire reset_n_i,
  input  wire async_i,
  input  wire rst_val_i,
  output wire sync_o
);
  reg meta_r;
  reg sync_r;
  always @(posedge sys_clk_i)
  begin
    if (!reset_n_i)
    begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end
    else
    begin
      meta_r <= async_i ^ rst_val_i;
      sync_r <= meta_r;
    end
  end
  assign sync_o = sync_r ^ rst_val_i;
endmodule
`default_nettype wire

/* File: sim/dac_serial_write_frontend_tb.sv */
// random frames, aborts and ignored bits against the front end
`default_nettype none
module dac_serial_write_frontend_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        sys_clk_i;
  logic        reset_n_i;
  wire         sel_n;
  wire         sclk;
  wire         sdat;
  wire  [15:0] dac;
  wire  [1:0]  mode;
  wire         upd;
  wire         abt;
  wire         pm_hi;
  wire         pm_lo;
  wire         busy;
  int          fail_count;
  int          compares;
  int          upd_n;
  int          abt_n;
  logic [15:0] exp_d;
  logic [1:0]  exp_m;
  dsw_master_model m (.frame_sel_n_o(sel_n), .ser_clk_o(sclk),
    .ser_data_o(sdat));
  dsw_frontend dut (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .frame_sel_n_i(sel_n), .ser_clk_i(sclk), .ser_data_i(sdat),
    .dac_data_o(dac), .power_mode_o(mode), .power_mode_bit_high_o(pm_hi),
    .power_mode_bit_low_o(pm_lo), .update_o(upd), .abort_o(abt),
    .busy_o(busy));
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i)
  begin
    upd_n += (upd === 1'b1);
    abt_n += (abt === 1'b1);
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task print_verdict;
    $display("errors=%0d compares=%0d", fail_count, compares);
    if (fail_count == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic xfer(input int n, input bit hold, input logic [1:0] md,
    input bit ign);
    logic [15:0] d;
    int          u;
    int          a;
    @(posedge sys_clk_i);
    #1;
    d = 16'($urandom);
    u = upd_n;
    a = abt_n;
    fork
      m.frame({6'($urandom), md, d}, n, hold);
      begin
        repeat (6) @(posedge sys_clk_i);
        #1;
        chk(16'(busy), 16'(!ign));
      end
    join
    repeat (8) @(posedge sys_clk_i);
    #1;
    if (n == 24)
    begin
      exp_d = d;
      exp_m = md;
    end
    chk(16'(upd_n - u), 16'(n == 24));
    chk(16'(abt_n - a), 16'(n < 24 && !ign));
    chk(dac, exp_d);
    chk({14'h0000, mode}, {14'h0000, exp_m});
    chk({14'h0000, pm_hi, pm_lo}, {14'h0000, exp_m});
    chk(16'(busy), 16'h0000);
  endtask
  initial
  begin
    fail_count = 0;
    compares = 0;
    upd_n = 0;
    abt_n = 0;
    exp_d = 16'h0000;
    exp_m = 2'h0;
    reset_n_i = 1'b0;
    void'($urandom(32'hFEDE));
    repeat (2) @(posedge sys_clk_i);
    #1 reset_n_i = 1'b1;
    repeat (4) @(posedge sys_clk_i);
    for (int i = 0; i < 8; i++) xfer(24, 0, 2'(i), 0);
    xfer(23, 0, 2'h3, 0);
    xfer(1, 0, 2'h1, 0);
    xfer(24, 1, 2'h2, 0);
    xfer(8, 0, 2'h1, 1);
    for (int i = 0; i < 4; i++)
      xfer(1 + $urandom % 23, 0, 2'(i), 0);
    // a reset in mid-run returns data and mode to zero
    @(posedge sys_clk_i);
    #1 reset_n_i = 1'b0;
    repeat (2) @(posedge sys_clk_i);
    #1 reset_n_i = 1'b1;
    exp_d = 16'h0000;
    exp_m = 2'h0;
    chk(dac, exp_d);
    chk({14'h0000, mode}, {14'h0000, exp_m});
    chk(16'(busy), 16'h0000);
    xfer(24, 0, 2'h0, 0);
    print_verdict();
  end
  initial
  begin
    #2000000;
    fail_count++;
    print_verdict();
  end
endmodule
`default_nettype wire

/* File: sim/dsw_frontend_properties.sv */
// timing checks on the front end ports
`default_nettype none
module dsw_props
(
  input wire logic        sys_clk_i,
  input wire logic        reset_n_i,
  input wire logic        frame_sel_n_i,
  input wire logic [15:0] dac_data_o,
  input wire logic [1:0]  power_mode_o,
  input wire logic        power_mode_bit_high_o,
  input wire logic        power_mode_bit_low_o,
  input wire logic        update_o,
  input wire logic        abort_o,
  input wire logic        busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  property p_upd; update_o |=> !update_o; endproperty
  a_upd: assert property (p_upd) else $error("upd");
  property p_abt; abort_o |=> !abort_o; endproperty
  a_abt: assert property (p_abt) else $error("abt");
  property p_dat; $changed(dac_data_o) |-> update_o; endproperty
  a_dat: assert property (p_dat) else $error("dat");
  property p_mod; $changed(power_mode_o) |-> update_o; endproperty
  a_mod: assert property (p_mod) else $error("mod");
  property p_bit;
    power_mode_o == {power_mode_bit_high_o, power_mode_bit_low_o};
  endproperty
  a_bit: assert property (p_bit) else $error("bit");
  property p_done; (update_o || abort_o) |-> !busy_o; endproperty
  a_done: assert property (p_done) else $error("done");
  property p_idle; frame_sel_n_i [*5] |-> !busy_o; endproperty
  a_idle: assert property (p_idle) else $error("idle");
  property p_start; $rose(busy_o) |-> !$past(frame_sel_n_i); endproperty
  a_start: assert property (p_start) else $error("start");
  c_upd: cover property (update_o);
  c_abt: cover property (abort_o);
  c_pd: cover property (update_o && power_mode_o != 2'h0);
endmodule
bind dsw_frontend dsw_props u_props
(
  .sys_clk_i             (sys_clk_i),
  .reset_n_i             (reset_n_i),
  .frame_sel_n_i         (frame_sel_n_i),
  .dac_data_o            (dac_data_o),
  .power_mode_o          (power_mode_o),
  .power_mode_bit_high_o (power_mode_bit_high_o),
  .power_mode_bit_low_o  (power_mode_bit_low_o),
  .update_o              (update_o),
  .abort_o               (abort_o),
  .busy_o                (busy_o)
);
`default_nettype wire

/* File: sim/dsw_master_model.sv */
// serial write master driving the frame pins
`default_nettype none
module dsw_master_model
(
  output logic frame_sel_n_o,
  output logic ser_clk_o,
  output logic ser_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    frame_sel_n_o = 1'b1;
    ser_clk_o = 1'b1;
    ser_data_o = 1'b0;
  end
  task automatic frame(input logic [23:0] w, input int n, input bit hold);
    frame_sel_n_o = 1'b0;
    #200;
    for (int i = 23; i > 23 - n; i--)
    begin
      ser_clk_o = 1'b1;
      ser_data_o = w[i];
      #200 ser_clk_o = 1'b0;
      #200;
    end
    if (!hold)
    begin
      frame_sel_n_o = 1'b1;
      ser_data_o = ~ser_data_o;
      #200;
    end
  endtask
endmodule
`default_nettype wire
